// ### design/irq_route.sv
// board interrupt routing, chain priority and baud clock selection
//
// What this block does
// - each source maps to line 0..7
// - several sources may share one line
// - controller scheme never drives shared request directly
// - chain board pulls its own line low
// - lower-numbered low line inhibits interrupting
// - nine levels; 0 senses none, 8 drives none
// - level n senses lines below n, drives n
// - line 0 sensed unless sense disable open; lowest level 1
// - fixed scheme: parallel direct or via counter
// - chain sensing off in other two schemes
// - channel clock internal or external, internal default
// - channel A receive/transmit share one clock
// - vector output only in select setting 2
// - sense disable open ignores line 0
`timescale 1ns/1ps
`include "irq_route_defines.svh"

module irq_route #(
  parameter int NUM_LINES = 8,
  parameter int DW        = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input  wire logic [7:0]           addr_in,
  input  wire logic [DW-1:0]        wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [DW-1:0]        rdata_out,
  input  wire logic [`NUM_SRC-1:0]  src_req_in,
  input  wire logic [NUM_LINES-1:0] vectored_priority_line_in,
  output logic      [NUM_LINES-1:0] vectored_priority_line_out,
  output logic      [NUM_LINES-1:0] vectored_priority_line_oe_n_out,
  input  wire logic                 int_req_n_in,
  output logic                      int_req_n_out,
  output logic                      int_req_n_oe_n_out,
  input  wire logic                 int_ack_in,
  output logic                      vector_drive_out,
  input  wire logic                 timer_ch0_in,
  input  wire logic                 timer_ch1_in,
  input  wire logic                 ext_clock_a_in,
  input  wire logic                 ext_clock_b_in,
  output logic                      channel_a_receive_clock_out,
  output logic                      channel_a_transmit_clock_out,
  output logic                      channel_b_clock_out
);

  localparam int SW = NUM_LINES + 4;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic irq_route_pkg::mode_t decode_mode(input logic [1:0] code);
    irq_route_pkg::mode_t m;
    m = irq_route_pkg::MODE_CHAIN;
    if (code == `MODE_CODE_CTRL) begin
      m = irq_route_pkg::MODE_CTRL;
    end else if (code == `MODE_CODE_FIXED) begin
      m = irq_route_pkg::MODE_FIXED;
    end
    return m;
  endfunction

  // lines numbered below the level
  function automatic logic [NUM_LINES-1:0] below_mask(input logic [3:0] lvl);
    logic [NUM_LINES-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (4'(i) < lvl) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // the one line equal to the level; none at the top level
  function automatic logic [NUM_LINES-1:0] level_onehot(input logic [3:0] lvl);
    logic [NUM_LINES-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (4'(i) == lvl) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  pin_sync_if #(.W(SW)) sync_bus ();

  assign sync_bus.raw = {int_req_n_in, ext_clock_b_in, ext_clock_a_in, int_ack_in, vectored_priority_line_in};

  pin_sync #(
    .W         (SW),
    .RESET_VAL ({4'h8, {NUM_LINES{1'b1}}})
  ) u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .port    (sync_bus.sync)
  );

  logic [NUM_LINES-1:0] lines_seen;
  logic                 ack_seen;
  logic                 ext_a_seen;
  logic                 ext_b_seen;

  assign lines_seen = sync_bus.stable[NUM_LINES-1:0];
  assign ack_seen   = sync_bus.stable[NUM_LINES];
  assign ext_a_seen = sync_bus.stable[NUM_LINES+1];
  assign ext_b_seen = sync_bus.stable[NUM_LINES+2];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [1:0]               mode_code;
  logic [1:0]               vsel;
  logic                     dsd_open;
  logic                     a_ext;
  logic                     b_ext;
  logic [3:0]               level;
  logic [`NUM_SRC-1:0]      direct_en;
  logic [`MAP_FIELD_W-1:0]  line_map [`NUM_SRC];
  logic [1:0]               next_mode_code;
  logic [1:0]               next_vsel;
  logic                     next_dsd_open;
  logic                     next_a_ext;
  logic                     next_b_ext;
  logic [3:0]               next_level;
  logic [`NUM_SRC-1:0]      next_direct_en;
  logic [`MAP_FIELD_W-1:0]  next_line_map [`NUM_SRC];
  logic [DW-1:0]            rdata;
  logic [DW-1:0]            next_rdata;

  irq_route_pkg::mode_t mode;
  assign mode = decode_mode(mode_code);

  always_comb begin
    next_mode_code = mode_code;
    next_vsel      = vsel;
    next_dsd_open  = dsd_open;
    next_a_ext     = a_ext;
    next_b_ext     = b_ext;
    next_level     = level;
    next_direct_en = direct_en;
    next_line_map  = line_map;
    if (wr_in) begin
      if (addr_in == `REG_CONTROL) begin
        next_mode_code = wdata_in[`CTL_MODE_MSB:`CTL_MODE_LSB];
        next_vsel      = wdata_in[`CTL_VSEL_MSB:`CTL_VSEL_LSB];
        next_dsd_open  = wdata_in[`CTL_DSD_BIT];
        next_a_ext     = wdata_in[`CTL_A_EXT_BIT];
        next_b_ext     = wdata_in[`CTL_B_EXT_BIT];
      end else if (addr_in == `REG_LEVEL) begin
        // level 0 belongs to the processor, so clamp to 1..8
        if (wdata_in[3:0] < `LEVEL_MIN) begin
          next_level = `LEVEL_MIN;
        end else if (wdata_in[3:0] > `LEVEL_MAX) begin
          next_level = `LEVEL_MAX;
        end else begin
          next_level = wdata_in[3:0];
        end
      end else if (addr_in == `REG_DIRECT_EN) begin
        next_direct_en = wdata_in[`NUM_SRC-1:0];
      end else if (addr_in == `REG_MAP_CT_SC) begin
        next_line_map[`SRC_CT] = wdata_in[2:0];
        next_line_map[`SRC_SC] = wdata_in[5:3];
      end else if (addr_in == `REG_MAP_PORT1) begin
        next_line_map[`SRC_P1A] = wdata_in[2:0];
        next_line_map[`SRC_P1B] = wdata_in[5:3];
      end else if (addr_in == `REG_MAP_PORT2) begin
        next_line_map[`SRC_P2A] = wdata_in[2:0];
        next_line_map[`SRC_P2B] = wdata_in[5:3];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_code <= `RST_MODE;
      vsel      <= `RST_VSEL;
      dsd_open  <= `RST_DSD;
      a_ext     <= `RST_EXT;
      b_ext     <= `RST_EXT;
      level     <= `RST_LEVEL;
      direct_en <= `RST_DIRECT_EN;
      for (int i = 0; i < `NUM_SRC; i++) begin
        line_map[i] <= `RST_MAP;
      end
    end else begin
      mode_code <= next_mode_code;
      vsel      <= next_vsel;
      dsd_open  <= next_dsd_open;
      a_ext     <= next_a_ext;
      b_ext     <= next_b_ext;
      level     <= next_level;
      direct_en <= next_direct_en;
      line_map  <= next_line_map;
    end
  end

  // ----------------------------------------------------------------
  // routing and chain priority
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] sense_mask;
  logic                 inhibit;
  logic [NUM_LINES-1:0] map_drive;
  logic                 any_src;
  logic                 direct_req;
  logic [NUM_LINES-1:0] next_line_oe_n;
  logic                 next_int_oe_n;
  logic                 next_vector_drive;

  always_comb begin
    // sensing only in the chain scheme; open disable drops line 0
    sense_mask = '0;
    if (mode == irq_route_pkg::MODE_CHAIN) begin
      sense_mask = below_mask(level);
      if (dsd_open) begin
        sense_mask[0] = 1'b0;
      end
    end
    inhibit = |(sense_mask & ~lines_seen);
  end

  // each source ORed onto whichever line it is mapped to
  always_comb begin
    map_drive = '0;
    for (int s = 0; s < `NUM_SRC; s++) begin
      for (int l = 0; l < NUM_LINES; l++) begin
        if (src_req_in[s] && (line_map[s] == `MAP_FIELD_W'(l))) begin
          map_drive[l] = 1'b1;
        end
      end
    end
  end

  assign any_src    = |src_req_in;
  assign direct_req = |(src_req_in & direct_en);

  always_comb begin
    next_line_oe_n    = '1;
    next_int_oe_n     = 1'b1;
    next_vector_drive = 1'b0;
    case (mode)
      irq_route_pkg::MODE_CTRL: begin
        next_line_oe_n = ~map_drive;
        next_int_oe_n  = 1'b1;
      end
      irq_route_pkg::MODE_FIXED: begin
        next_int_oe_n = ~direct_req;
      end
      irq_route_pkg::MODE_CHAIN: begin
        if (any_src) begin
          next_line_oe_n = ~level_onehot(level);
        end
        next_int_oe_n = ~(direct_req && !inhibit);
        next_vector_drive = ack_seen && (vsel == `VSEL_DRIVE);
      end
      default: begin
        next_line_oe_n = '1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // baud clock selection
  // ----------------------------------------------------------------
  logic next_clk_a;
  logic next_clk_b;

  assign next_clk_a = a_ext ? ext_a_seen : timer_ch0_in;
  assign next_clk_b = b_ext ? ext_b_seen : timer_ch1_in;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (rd_in) begin
      if (addr_in == `REG_CONTROL) begin
        next_rdata = DW'({b_ext, a_ext, dsd_open, vsel, mode_code});
      end else if (addr_in == `REG_LEVEL) begin
        next_rdata = DW'(level);
      end else if (addr_in == `REG_DIRECT_EN) begin
        next_rdata = DW'(direct_en);
      end else if (addr_in == `REG_MAP_CT_SC) begin
        next_rdata = DW'({line_map[`SRC_SC], line_map[`SRC_CT]});
      end else if (addr_in == `REG_MAP_PORT1) begin
        next_rdata = DW'({line_map[`SRC_P1B], line_map[`SRC_P1A]});
      end else if (addr_in == `REG_MAP_PORT2) begin
        next_rdata = DW'({line_map[`SRC_P2B], line_map[`SRC_P2A]});
      end else if (addr_in == `REG_STATUS) begin
        next_rdata = DW'({~sync_bus.stable[NUM_LINES+3], vector_drive_out,
                          ~(&vectored_priority_line_oe_n_out),
                          ~int_req_n_oe_n_out, inhibit});
      end else if (addr_in == `REG_LINES) begin
        next_rdata = DW'(lines_seen);
      end else if (addr_in == `REG_SOURCES) begin
        next_rdata = DW'(src_req_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata                           <= '0;
      vectored_priority_line_out      <= '0;
      vectored_priority_line_oe_n_out <= '1;
      int_req_n_out                   <= 1'b0;
      int_req_n_oe_n_out              <= 1'b1;
      vector_drive_out                <= 1'b0;
      channel_a_receive_clock_out     <= 1'b0;
      channel_a_transmit_clock_out    <= 1'b0;
      channel_b_clock_out             <= 1'b0;
    end else begin
      rdata                           <= next_rdata;
      vectored_priority_line_out      <= '0;
      vectored_priority_line_oe_n_out <= next_line_oe_n;
      int_req_n_out                   <= 1'b0;
      int_req_n_oe_n_out              <= next_int_oe_n;
      vector_drive_out                <= next_vector_drive;
      channel_a_receive_clock_out     <= next_clk_a;
      channel_a_transmit_clock_out    <= next_clk_a;
      channel_b_clock_out             <= next_clk_b;
    end
  end

  assign rdata_out = rdata;

endmodule // irq_route

// ### design/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync #(
  parameter int           W         = 11,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  pin_sync_if.sync  port
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] stable;
  logic [W-1:0] next_stable;

  // ----------------------------------------------------------------
  // a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_stable[i] = (stage2[i] == stage3[i]) ? stage3[i] : stable[i];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      stable <= RESET_VAL;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
    end
  end

  assign port.stable = stable;

endmodule // pin_sync

// ### inc/irq_route_defines.svh
// register offsets, field positions, reset values and widths of the interrupt router
`ifndef IRQ_ROUTE_DEFINES_SVH
`define IRQ_ROUTE_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CONTROL        8'h00
`define REG_LEVEL          8'h01
`define REG_DIRECT_EN      8'h02
`define REG_MAP_CT_SC      8'h03
`define REG_MAP_PORT1      8'h04
`define REG_MAP_PORT2      8'h05
`define REG_STATUS         8'h06
`define REG_LINES          8'h07
`define REG_SOURCES        8'h08

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTL_MODE_LSB       0
`define CTL_MODE_MSB       1
`define CTL_VSEL_LSB       2
`define CTL_VSEL_MSB       3
`define CTL_DSD_BIT        4
`define CTL_A_EXT_BIT      5
`define CTL_B_EXT_BIT      6

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define MODE_CODE_CTRL     2'h0
`define MODE_CODE_FIXED    2'h1
`define MODE_CODE_CHAIN    2'h2
`define VSEL_DRIVE         2'h2
`define RST_MODE           2'h2
`define RST_VSEL           2'h2
`define RST_DSD            1'h0
`define RST_EXT            1'h0
`define RST_LEVEL          4'h3
`define RST_DIRECT_EN      6'h03
`define RST_MAP            3'h0
`define LEVEL_MIN          4'h1
`define LEVEL_MAX          4'h8
`define MAP_FIELD_W        3

// ----------------------------------------------------------------
// source indices
// ----------------------------------------------------------------
`define SRC_CT             0
`define SRC_SC             1
`define SRC_P1A            2
`define SRC_P1B            3
`define SRC_P2A            4
`define SRC_P2B            5
`define NUM_SRC            6

`endif

// ### inc/irq_route_pkg.sv
// types shared by the interrupt router
package irq_route_pkg;

  typedef enum logic [2:0] {
    MODE_CTRL  = 3'b001,
    MODE_FIXED = 3'b010,
    MODE_CHAIN = 3'b100
  } mode_t;

endpackage

// ### inc/pin_sync_if.sv
// carrier between the router and its pin synchroniser
`timescale 1ns/1ps

interface pin_sync_if #(parameter int W = 11);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// ### verif/far_bus_model.sv
// far side of the bus: other boards, pull-ups and the host
`timescale 1ns/1ps

module far_bus_model (
  input  wire logic [7:0]  line_oe_n_in,
  input  wire logic        req_oe_n_in,
  input  wire logic [7:0]  board_pull_in,
  input  wire logic        ctrl_req_in,
  output logic      [7:0]  lines_out,
  output logic             req_n_out,
  output logic      [15:0] restart_addr_out
);
  // released lines rise through pull-ups; other boards hold one level each
  assign lines_out = line_oe_n_in & ~board_pull_in;
  // the system controller may pull the shared request as well
  assign req_n_out = req_oe_n_in & ~ctrl_req_in;
  assign restart_addr_out = req_n_out ? 16'h0000 : 16'h0038;
endmodule // far_bus_model

// ### verif/irq_route_asserts.sv
// port-level checks for the interrupt router
`timescale 1ns/1ps

module irq_route_asserts #(
  parameter int NUM_LINES = 8,
  parameter int DW        = 8
) (
  input wire logic                 clk_in,
  input wire logic                 nrst_in,
  input wire logic [7:0]           addr_in,
  input wire logic [DW-1:0]        wdata_in,
  input wire logic                 wr_in,
  input wire logic [5:0]           src_req_in,
  input wire logic [NUM_LINES-1:0] vectored_priority_line_out,
  input wire logic [NUM_LINES-1:0] vectored_priority_line_oe_n_out,
  input wire logic                 int_req_n_out,
  input wire logic                 int_req_n_oe_n_out,
  input wire logic                 vector_drive_out,
  input wire logic                 timer_ch1_in,
  input wire logic                 channel_a_receive_clock_out,
  input wire logic                 channel_a_transmit_clock_out,
  input wire logic                 channel_b_clock_out
);
  // ----------------------------------------------------------------
  // shadow of the configuration written over the bus
  // ----------------------------------------------------------------
  logic [1:0] mode, vsel, next_mode, next_vsel;
  logic [3:0] level, next_level;
  logic       b_ext, next_b_ext;

  always_comb begin
    next_mode  = mode;
    next_vsel  = vsel;
    next_b_ext = b_ext;
    next_level = level;
    if (wr_in && addr_in == 8'h00) begin
      next_mode  = wdata_in[1:0];
      next_vsel  = wdata_in[3:2];
      next_b_ext = wdata_in[6];
    end
    if (wr_in && addr_in == 8'h01) begin
      next_level = (wdata_in[3:0] == 4'h0) ? 4'h1 : (wdata_in[3:0] > 4'h8) ? 4'h8 : wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode  <= 2'h2;
      vsel  <= 2'h2;
      b_ext <= 1'h0;
      level <= 4'h3;
    end else begin
      mode  <= next_mode;
      vsel  <= next_vsel;
      b_ext <= next_b_ext;
      level <= next_level;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence chain_req_s;
    mode[1] && src_req_in != 6'h00 && level != 4'h8;
  endsequence

  sequence idle_s;
    src_req_in == 6'h00;
  endsequence

  drive_zero_a: assert property (vectored_priority_line_out == '0 && !int_req_n_out)
    else $error("drive value not zero");
  idle_release_a: assert property (idle_s |=> &vectored_priority_line_oe_n_out && int_req_n_oe_n_out)
    else $error("line held while idle");
  own_line_a: assert property (chain_req_s |=>
    vectored_priority_line_oe_n_out == ~(NUM_LINES'(1) << $past(level)))
    else $error("wrong chain line driven");
  top_silent_a: assert property (mode[1] && level == 4'h8 |=> &vectored_priority_line_oe_n_out)
    else $error("level 8 drove a line");
  ctrl_no_req_a: assert property (mode == 2'h0 |=> int_req_n_oe_n_out)
    else $error("shared request driven in controller scheme");
  fixed_no_line_a: assert property (mode == 2'h1 |=> &vectored_priority_line_oe_n_out)
    else $error("line driven in fixed scheme");
  vector_gate_a: assert property (vector_drive_out |-> $past(vsel) == 2'h2 && $past(mode[1]))
    else $error("vector driven outside setting 2");
  chan_a_pair_a: assert property (channel_a_receive_clock_out == channel_a_transmit_clock_out)
    else $error("channel a clocks differ");
  chan_b_int_a: assert property (!b_ext |=> channel_b_clock_out == $past(timer_ch1_in))
    else $error("channel b not on timer clock");
endmodule // irq_route_asserts

bind irq_route irq_route_asserts #(.NUM_LINES(NUM_LINES), .DW(DW)) u_irq_route_asserts (
  .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .src_req_in, .vectored_priority_line_out,
  .vectored_priority_line_oe_n_out, .int_req_n_out, .int_req_n_oe_n_out, .vector_drive_out, .timer_ch1_in,
  .channel_a_receive_clock_out, .channel_a_transmit_clock_out, .channel_b_clock_out
);

// ### verif/testbench.sv
// self-checking bench for the interrupt router
`timescale 1ns/1ps
`include "irq_route_defines.svh"

module testbench;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [5:0]  src_req_in = 6'h00;
  logic        int_ack_in = 1'b0;
  logic [3:0]  clk_src = 4'h0;
  logic [7:0]  board_pull = 8'h00;
  logic        ctrl_req = 1'b0;
  logic [7:0]  rdata_out, line_val, line_oe_n;
  logic        req_oe_n, req_val, vector_drive_out, ca_rx, ca_tx, cb;
  logic [31:0] rng = 32'h0000001A;
  logic [7:0]  pull_tab [5] = '{8'h08, 8'h40, 8'h01, 8'h01, 8'h09};
  logic [4:0]  dsd_tab = 5'h18;
  int          num_errors = 0;
  int          check_count = 0;

  always #5 clk_in = ~clk_in;

  irq_route uut (
    .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .src_req_in,
    .vectored_priority_line_in(line_val), .vectored_priority_line_out(),
    .vectored_priority_line_oe_n_out(line_oe_n), .int_req_n_in(req_val), .int_req_n_out(),
    .int_req_n_oe_n_out(req_oe_n), .int_ack_in, .vector_drive_out, .timer_ch0_in(clk_src[0]),
    .timer_ch1_in(clk_src[1]), .ext_clock_a_in(clk_src[2]), .ext_clock_b_in(clk_src[3]),
    .channel_a_receive_clock_out(ca_rx), .channel_a_transmit_clock_out(ca_tx), .channel_b_clock_out(cb)
  );

  far_bus_model partner (
    .line_oe_n_in(line_oe_n), .req_oe_n_in(req_oe_n), .board_pull_in(board_pull),
    .ctrl_req_in(ctrl_req), .lines_out(line_val), .req_n_out(req_val), .restart_addr_out()
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [7:0] chain_lines(input logic [3:0] lvl, input logic [5:0] src);
    return (src != 6'h00 && lvl < 4'h8) ? ~(8'h01 << lvl) : 8'hFF;
  endfunction

  function automatic logic chain_req(input logic [3:0] lvl, input logic [5:0] src, input logic [7:0] lines,
                                     input logic dsd);
    logic [7:0] sensed;
    sensed = (8'h01 << lvl) - 8'h01;
    if (dsd) sensed[0] = 1'b0;
    return !((src != 6'h00) && ((~lines & sensed) == 8'h00));
  endfunction

  function automatic logic [7:0] ctrl_lines(input logic [17:0] map, input logic [5:0] src);
    logic [7:0] drv;
    drv = 8'h00;
    for (int i = 0; i < 6; i++) if (src[i]) drv[map[3*i +: 3]] = 1'b1;
    return ~drv;
  endfunction

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic reg_read(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(name, exp, rdata_out);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [17:0] map;
    logic [5:0]  en;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    reg_read("control", `REG_CONTROL, 8'h0A);
    reg_read("level", `REG_LEVEL, 8'h03);
    reg_read("direct_en", `REG_DIRECT_EN, 8'h03);
    for (int a = 3; a < 6; a++) reg_read("map", 8'(a), 8'h00);
    reg_write(8'h20, 8'h5A);
    reg_read("unmapped", 8'h20, 8'h00);
    reg_write(`REG_SOURCES, 8'h3F);
    reg_read("sources", `REG_SOURCES, 8'h00);
    reg_write(`REG_LEVEL, 8'h00);
    reg_read("level low", `REG_LEVEL, 8'h01);
    reg_write(`REG_LEVEL, 8'h0F);
    reg_read("level high", `REG_LEVEL, 8'h08);
    // chain scheme over every level
    reg_write(`REG_DIRECT_EN, 8'h3F);
    for (int l = 1; l <= 8; l++) begin
      reg_write(`REG_LEVEL, 8'(l));
      src_req_in <= 6'(xorshift()) | 6'h01;
      cycles(6);
      check("chain lines", chain_lines(4'(l), src_req_in), line_oe_n);
      check("chain req", {7'h00, chain_req(4'(l), src_req_in, 8'hFF, 1'b0)}, {7'h00, req_oe_n});
    end
    // other boards holding lines around level 5
    reg_write(`REG_LEVEL, 8'h05);
    src_req_in <= 6'h01;
    for (int k = 0; k < 5; k++) begin
      reg_write(`REG_CONTROL, dsd_tab[k] ? 8'h1A : 8'h0A);
      board_pull <= pull_tab[k];
      cycles(6);
      check("inhibit", {7'h00, chain_req(4'h5, 6'h01, ~pull_tab[k], dsd_tab[k])}, {7'h00, req_oe_n});
      check("own line", 8'hDF, line_oe_n);
    end
    // vector output select settings during acknowledge
    reg_write(`REG_CONTROL, 8'h0A);
    board_pull <= 8'h00;
    int_ack_in <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      reg_write(`REG_CONTROL, {4'h0, 2'(v), 2'h2});
      cycles(6);
      check("vector", {7'h00, v == 2}, {7'h00, vector_drive_out});
    end
    // controller scheme with line 0 held by the processor
    board_pull <= 8'h01;
    ctrl_req <= 1'b1;
    reg_write(`REG_CONTROL, 8'h18);
    for (int n = 0; n < 12; n++) begin
      map = (n == 0) ? 18'h0 : 18'(xorshift());
      reg_write(`REG_MAP_CT_SC, {2'h0, map[5:0]});
      reg_write(`REG_MAP_PORT1, {2'h0, map[11:6]});
      reg_write(`REG_MAP_PORT2, {2'h0, map[17:12]});
      src_req_in <= (n < 2) ? 6'h3F : 6'(xorshift());
      cycles(2);
      check("ctrl lines", ctrl_lines(map, src_req_in), line_oe_n);
      check("ctrl req", 8'h01, {7'h00, req_oe_n});
      check("ctrl vector", 8'h00, {7'h00, vector_drive_out});
    end
    cycles(4);
    reg_read("status", `REG_STATUS, {3'h0, 2'h2, ctrl_lines(map, src_req_in) != 8'hFF, 2'h0});
    reg_read("lines", `REG_LINES, ctrl_lines(map, src_req_in) & 8'hFE);
    // fixed restart scheme, counter route then direct parallel route
    board_pull <= 8'h09;
    ctrl_req <= 1'b0;
    reg_write(`REG_CONTROL, 8'h19);
    for (int n = 0; n < 8; n++) begin
      en = (n < 4) ? 6'h03 : 6'h3F;
      reg_write(`REG_DIRECT_EN, {2'h0, en});
      src_req_in <= (n == 4) ? 6'h3C : 6'(xorshift());
      cycles(2);
      check("fixed req", {7'h00, (src_req_in & en) == 6'h00}, {7'h00, req_oe_n});
      check("fixed lines", 8'hFF, line_oe_n);
    end
    // baud clock sources
    for (int c = 0; c < 8; c++) begin
      reg_write(`REG_CONTROL, {1'b0, 2'(c), 5'h0A});
      clk_src <= 4'(xorshift());
      cycles(6);
      check("chan a rx", {7'h00, c[0] ? clk_src[2] : clk_src[0]}, {7'h00, ca_rx});
      check("chan a tx", {7'h00, c[0] ? clk_src[2] : clk_src[0]}, {7'h00, ca_tx});
      check("chan b", {7'h00, c[1] ? clk_src[3] : clk_src[1]}, {7'h00, cb});
    end
    // reset in mid-run brings back the defaults
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    reg_read("control again", `REG_CONTROL, 8'h0A);
    reg_read("level again", `REG_LEVEL, 8'h03);
    complete_run();
  end
endmodule // testbench
